// [design/iou_defs.svh]
`ifndef IOU_DEFS_SVH
`define IOU_DEFS_SVH
// Clock and internal sampling
`define IOU_CLK_HZ      50000000
`define IOU_INT_RATE_HZ 2000
`define IOU_TICK_CYC    (`IOU_CLK_HZ / `IOU_INT_RATE_HZ)
// Gyro alignment delay, microseconds, and its length in internal samples
`define IOU_GYRO_DLY_US 1000
`define IOU_DLY_SAMPLES (`IOU_GYRO_DLY_US * `IOU_INT_RATE_HZ / 1000000)
// Bit of the gyro unit code that selects the delayed path (code >= 8)
`define IOU_DLY_BIT     3
// Scale factors, Q16: one internal period times unit conversion
`define IOU_FRAC        16
`define IOU_K_ANGLE     13'h1062
`define IOU_K_VEL       13'h0A0B
`define IOU_K_GS        13'h0106
// Dividend width and divider step count
`define IOU_SUM_W       36
`define IOU_DIV_STEPS   6'h24
`define IOU_BYTES       3'h5
`endif

// [design/iou_fifo.sv]
`timescale 1ns/1ps
module iou_fifo #(
   parameter int W     = 48,
   parameter int DEPTH = 4
) (
   input  wire logic         mclk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] inData,
   input  wire logic         inValid,
   output logic              inReady,
   output logic [W-1:0]      outData,
   output logic              outValid,
   input  wire logic         outReady
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wrPtr_ff;
   logic [AW:0]  rdPtr_ff;
   logic         full;
   logic         empty;

   assign empty    = (wrPtr_ff == rdPtr_ff);
   assign full     = (wrPtr_ff[AW] != rdPtr_ff[AW]) && (wrPtr_ff[AW-1:0] == rdPtr_ff[AW-1:0]);
   assign inReady  = !full;
   assign outValid = !empty;
   assign outData  = mem[rdPtr_ff[AW-1:0]];

   always_ff @(posedge mclk)
   begin
      if (inValid && !full)
      begin
         mem[wrPtr_ff[AW-1:0]] <= inData;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
      end
      else
      begin
         if (inValid && !full)
         begin
            wrPtr_ff <= wrPtr_ff + 1'b1;
         end
         if (outReady && !empty)
         begin
            rdPtr_ff <= rdPtr_ff + 1'b1;
         end
      end
   end
endmodule : iou_fifo

// [design/iou_pkg.sv]
package iou_pkg;
   typedef enum logic [1:0] {
      IOU_RATE  = 2'h0,
      IOU_INCR  = 2'h1,
      IOU_AVG   = 2'h2,
      IOU_INTEG = 2'h3
   } iou_unit_t;

   typedef enum logic [2:0] {
      S_IDLE = 3'b001,
      S_DIV  = 3'b010,
      S_PUSH = 3'b100
   } iou_state_t;
endpackage : iou_pkg

// [design/iou_top.sv]
`timescale 1ns/1ps
`include "iou_defs.svh"
module iou_top
   import iou_pkg::*;
#(
   parameter int TICK_CYC = `IOU_TICK_CYC,
   parameter int NW       = 11,
   parameter int DEPTH    = 4
) (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic [23:0] gyroSample,
   input  wire logic [23:0] accSample,
   input  wire logic [3:0]  gyroUnit,
   input  wire logic [1:0]  accUnit,
   input  wire logic [NW-1:0] txDiv,
   input  wire logic        byteReady,
   output logic [7:0]       byteOut_ff,
   output logic             byteValid_ff,
   output logic             overrun_ff,
   output logic             tick_ff
);
   localparam int TW = $clog2(TICK_CYC + 1);
   localparam int SW = `IOU_SUM_W;

   logic [TW-1:0]       tickCnt_ff;
   logic [NW-1:0]       sampCnt_ff;
   logic [NW-1:0]       nEff;
   logic                capture;
   logic signed [23:0]  dly_ff [`IOU_DLY_SAMPLES];
   logic signed [23:0]  gyroIn;
   iou_state_t          st_ff;
   logic [5:0]          divCnt_ff;
   logic [23:0]         word_ff [2];
   logic [23:0]         outWord [2];
   logic signed [SW-1:0] sum_ff [2];
   logic signed [39:0]  inc_ff [2];
   logic signed [39:0]  int_ff [2];
   logic signed [39:0]  prodT [2];
   logic signed [39:0]  nxtInc [2];
   logic [SW-1:0]       dvd_ff [2];
   logic [NW-1:0]       rem_ff [2];
   logic                neg_ff [2];
   logic [47:0]         fifoData;
   logic                fifoValid;
   logic                fifoInReady;
   logic                fifoPop;
   logic [47:0]         sh_ff;
   logic [2:0]          left_ff;

   // Free-running internal sample tick, independent of the transmit rate
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         tickCnt_ff <= '0;
         tick_ff    <= 1'b0;
      end
      else
      begin
         tick_ff <= (tickCnt_ff == TW'(TICK_CYC - 1));
         tickCnt_ff <= (tickCnt_ff == TW'(TICK_CYC - 1)) ? '0 : tickCnt_ff + 1'b1;
      end
   end

   // A divisor of zero is treated as one sample per transmission
   assign nEff    = (txDiv == '0) ? NW'(1) : txDiv;
   assign capture = tick_ff && (sampCnt_ff >= nEff - 1'b1);

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         sampCnt_ff <= '0;
      end
      else if (tick_ff)
      begin
         sampCnt_ff <= capture ? '0 : sampCnt_ff + 1'b1;
      end
   end

   // Gyro delay line shifts on every internal sample
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < `IOU_DLY_SAMPLES; i++)
         begin
            dly_ff[i] <= '0;
         end
      end
      else if (tick_ff)
      begin
         dly_ff[0] <= gyroSample;
         for (int i = 1; i < `IOU_DLY_SAMPLES; i++)
         begin
            dly_ff[i] <= dly_ff[i-1];
         end
      end
   end

   assign gyroIn = gyroUnit[`IOU_DLY_BIT] ? dly_ff[`IOU_DLY_SAMPLES-1] : gyroSample;

   for (genvar c = 0; c < 2; c++)
   begin : g_chan
      localparam logic [12:0] K_INC = (c == 0) ? `IOU_K_ANGLE : `IOU_K_VEL;
      localparam logic [12:0] K_INT = (c == 0) ? `IOU_K_ANGLE : `IOU_K_GS;
      logic signed [23:0]   s;
      logic [1:0]           mode;
      logic signed [SW-1:0] nxtSum;
      logic [SW-1:0]        absSum;
      logic [NW:0]          remSh;
      logic signed [39:0]   prodI;

      // Samples arrive already low-pass filtered; averaging never sees raw data
      assign s      = (c == 0) ? gyroIn : $signed(accSample);
      assign mode   = (c == 0) ? gyroUnit[1:0] : accUnit;
      assign prodI  = 40'(s) * 40'($signed({1'b0, K_INC}));
      assign prodT[c] = 40'(s) * 40'($signed({1'b0, K_INT}));
      assign nxtSum = sum_ff[c] + SW'(s);
      assign nxtInc[c] = inc_ff[c] + prodI;
      assign absSum = nxtSum[SW-1] ? SW'(-nxtSum) : SW'(nxtSum);
      assign remSh  = {rem_ff[c], dvd_ff[c][SW-1]};

      // Interval sums restart at capture; the integrator only on reset
      always_ff @(posedge mclk)
      begin
         if (!rst_n)
         begin
            sum_ff[c] <= '0;
            inc_ff[c] <= '0;
            int_ff[c] <= '0;
         end
         else if (tick_ff)
         begin
            int_ff[c] <= int_ff[c] + prodT[c];
            sum_ff[c] <= capture ? '0 : nxtSum;
            inc_ff[c] <= capture ? '0 : nxtInc[c];
         end
      end

      // Latch the word; averages go through the serial divider first
      always_ff @(posedge mclk)
      begin
         if (!rst_n)
         begin
            word_ff[c] <= '0;
            dvd_ff[c]  <= '0;
            rem_ff[c]  <= '0;
            neg_ff[c]  <= 1'b0;
         end
         else if (capture && st_ff == S_IDLE)
         begin
            unique case (mode)
               IOU_RATE:  word_ff[c] <= s;
               IOU_INCR:  word_ff[c] <= nxtInc[c][`IOU_FRAC +: 24];
               IOU_AVG:   word_ff[c] <= '0;
               IOU_INTEG: word_ff[c] <= 24'((int_ff[c] + prodT[c]) >>> `IOU_FRAC);
            endcase
            dvd_ff[c] <= absSum;
            rem_ff[c] <= '0;
            neg_ff[c] <= nxtSum[SW-1];
         end
         else if (st_ff == S_DIV)
         begin
            if (remSh >= {1'b0, nEff})
            begin
               rem_ff[c] <= NW'(remSh - {1'b0, nEff});
               dvd_ff[c] <= {dvd_ff[c][SW-2:0], 1'b1};
            end
            else
            begin
               rem_ff[c] <= NW'(remSh);
               dvd_ff[c] <= {dvd_ff[c][SW-2:0], 1'b0};
            end
         end
      end

      // Mean uses the same scaling as the plain word
      assign outWord[c] = (mode != IOU_AVG) ? word_ff[c] :
                          neg_ff[c] ? 24'(-dvd_ff[c][23:0]) : dvd_ff[c][23:0];

      property p_rem_bound;
         @(posedge mclk) disable iff (!rst_n) st_ff == S_PUSH |-> rem_ff[c] < nEff;
      endproperty
      a_rem_bound: assert property (p_rem_bound) else $error("average remainder out of range");
      property p_sum_clear;
         @(posedge mclk) disable iff (!rst_n) capture |=> sum_ff[c] == '0 && inc_ff[c] == '0;
      endproperty
      a_sum_clear: assert property (p_sum_clear) else $error("interval sum not cleared");
   end

   // Result sequencing; a capture while busy is counted as overrun
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         st_ff      <= S_IDLE;
         divCnt_ff  <= '0;
         overrun_ff <= 1'b0;
      end
      else
      begin
         if (capture && st_ff != S_IDLE)
         begin
            overrun_ff <= 1'b1;
         end
         unique case (st_ff)
            S_IDLE:
            begin
               if (capture)
               begin
                  st_ff     <= S_DIV;
                  divCnt_ff <= '0;
               end
            end
            S_DIV:
            begin
               divCnt_ff <= divCnt_ff + 1'b1;
               if (divCnt_ff == `IOU_DIV_STEPS - 1'b1)
               begin
                  st_ff <= S_PUSH;
               end
            end
            S_PUSH:
            begin
               if (fifoInReady)
               begin
                  st_ff <= S_IDLE;
               end
            end
         endcase
      end
   end

   iou_fifo #(
      .W     (48),
      .DEPTH (DEPTH)
   ) u_fifo (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .inData   ({outWord[0], outWord[1]}),
      .inValid  (st_ff == S_PUSH),
      .inReady  (fifoInReady),
      .outData  (fifoData),
      .outValid (fifoValid),
      .outReady (fifoPop)
   );

   // Byte serialiser: gyro word then accel word, MSB first
   assign fifoPop = fifoValid && (!byteValid_ff || byteReady) && (left_ff == '0);

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         byteOut_ff   <= '0;
         byteValid_ff <= 1'b0;
         sh_ff        <= '0;
         left_ff      <= '0;
      end
      else if (!byteValid_ff || byteReady)
      begin
         if (left_ff != '0)
         begin
            byteOut_ff   <= sh_ff[47:40];
            sh_ff        <= {sh_ff[39:0], 8'h00};
            left_ff      <= left_ff - 1'b1;
            byteValid_ff <= 1'b1;
         end
         else if (fifoValid)
         begin
            byteOut_ff   <= fifoData[47:40];
            sh_ff        <= {fifoData[39:0], 8'h00};
            left_ff      <= `IOU_BYTES;
            byteValid_ff <= 1'b1;
         end
         else
         begin
            byteValid_ff <= 1'b0;
         end
      end
   end

   logic [TW-1:0] sinceTick_ff;
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         // All ones, so the first period after reset counts like the later ones
         sinceTick_ff <= '1;
      end
      else if (tick_ff)
      begin
         sinceTick_ff <= '0;
      end
      else
      begin
         sinceTick_ff <= sinceTick_ff + 1'b1;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_capIdle;
      capture && st_ff == S_IDLE;
   endsequence
   sequence s_load;
      fifoPop;
   endsequence

   property p_tick_period;
      tick_ff && $past(tick_ff, 2) == 1'b0 && sinceTick_ff != '0 |-> sinceTick_ff == TW'(TICK_CYC - 1);
   endproperty
   a_tick_period: assert property (p_tick_period) else $error("internal tick period wrong");

   property p_tick_gap;
      tick_ff |=> !tick_ff [*8];
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("internal ticks too close");

   property p_no_delay;
      !gyroUnit[`IOU_DLY_BIT] |-> gyroIn == $signed(gyroSample);
   endproperty
   a_no_delay: assert property (p_no_delay) else $error("gyro delayed without request");

   property p_delay;
      tick_ff && gyroUnit[`IOU_DLY_BIT] |=> dly_ff[0] == $past(gyroSample) && gyroIn == dly_ff[`IOU_DLY_SAMPLES-1];
   endproperty
   a_delay: assert property (p_delay) else $error("gyro delay path wrong");

   property p_rate;
      s_capIdle and gyroUnit[1:0] == IOU_RATE |=> word_ff[0] == $past(gyroIn);
   endproperty
   a_rate: assert property (p_rate) else $error("rate word not the sample");

   property p_incr;
      s_capIdle and accUnit == IOU_INCR |=> word_ff[1] == $past(nxtInc[1][`IOU_FRAC +: 24]);
   endproperty
   a_incr: assert property (p_incr) else $error("incremental word wrong");

   property p_integ;
      tick_ff |=> int_ff[0] == $past(int_ff[0]) + $past(prodT[0]) &&
                  (!$rose(overrun_ff) || $past(st_ff) != S_IDLE);
   endproperty
   a_integ: assert property (p_integ) else $error("integrator wrong or flagged");

   property p_push;
      s_capIdle |=> st_ff == S_DIV ##[36:36] st_ff == S_PUSH;
   endproperty
   a_push: assert property (p_push) else $error("divider length wrong");

   property p_msb_first;
      s_load |=> byteValid_ff && byteOut_ff == $past(fifoData[47:40]) && left_ff == `IOU_BYTES;
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("first byte not MSB");
endmodule : iou_top

// [dv/iou_sink.sv]
`timescale 1ns/1ps
module iou_sink (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic [7:0] byteOut_ff,
   input  wire logic       byteValid_ff,
   input  wire logic       stall,
   input  wire logic       slow,
   output logic            byteReady
);
   logic [7:0] q[$];

   // Slow mode drops ready every other cycle so the byte register must hold its value
   always @(posedge mclk)
   begin
      if (!rst_n)
      begin
         byteReady <= 1'b0;
      end
      else
      begin
         if (byteValid_ff && byteReady)
         begin
            q.push_back(byteOut_ff);
         end
         byteReady <= !stall && !(slow && byteReady);
      end
   end
endmodule : iou_sink

// [dv/tb_top.sv]
`timescale 1ns/1ps
`include "iou_defs.svh"
`define CHK(got, exp) begin nTests++; if ((got) !== (exp)) begin nErrors++; \
   $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
   localparam int TICK = 64;
   localparam int CEIL = 30000;
   logic        mclk       = 1'b0;
   logic        rst_n      = 1'b0;
   logic [23:0] gyroSample = 24'h000000;
   logic [23:0] accSample  = 24'h000000;
   logic [23:0] gStep      = 24'h000000;
   logic [3:0]  gyroUnit   = 4'h0;
   logic [1:0]  accUnit    = 2'h0;
   logic [10:0] txDiv      = 11'h001;
   logic        stall      = 1'b0;
   logic        slow       = 1'b0;
   logic        byteReady;
   logic [7:0]  byteOut;
   logic        byteValid;
   logic        overrun;
   logic        tick;
   int          nErrors    = 0;
   int          nTests     = 0;
   int          cyc        = 0;
   logic [47:0] w;

   always #10 mclk = ~mclk;

   iou_top #(.TICK_CYC(TICK)) dut (
      .mclk         (mclk),
      .rst_n        (rst_n),
      .gyroSample   (gyroSample),
      .accSample    (accSample),
      .gyroUnit     (gyroUnit),
      .accUnit      (accUnit),
      .txDiv        (txDiv),
      .byteReady    (byteReady),
      .byteOut_ff   (byteOut),
      .byteValid_ff (byteValid),
      .overrun_ff   (overrun),
      .tick_ff      (tick)
   );

   iou_sink sink (
      .mclk         (mclk),
      .rst_n        (rst_n),
      .byteOut_ff   (byteOut),
      .byteValid_ff (byteValid),
      .stall        (stall),
      .slow         (slow),
      .byteReady    (byteReady)
   );

   // Ramp moves the gyro input right after each internal sample is taken
   always @(posedge mclk)
   begin
      cyc++;
      if (tick === 1'b1 && rst_n === 1'b1)
      begin
         gyroSample <= gyroSample + gStep;
      end
      if (cyc == CEIL)
      begin
         nErrors++;
         results();
      end
   end

   function automatic logic [23:0] scaled(input longint s, input longint k);
      longint p;
      p = s * k;
      return p[39:16];
   endfunction : scaled

   task automatic setup(input logic [3:0] gu, input logic [1:0] au, input logic [10:0] n,
                        input logic [23:0] g0, input logic [23:0] a0, input logic [23:0] st);
      @(posedge mclk);
      rst_n      <= 1'b0;
      // Inputs move only once reset is seen, so the ramp never writes them in the same step
      @(posedge mclk);
      gyroUnit   <= gu;
      accUnit    <= au;
      txDiv      <= n;
      gyroSample <= g0;
      accSample  <= a0;
      gStep      <= st;
      stall      <= 1'b0;
      slow       <= 1'b0;
      @(posedge mclk);
      rst_n <= 1'b1;
      sink.q.delete();
   endtask : setup

   task automatic getWord(output logic [47:0] wd);
      int i = 0;
      while (sink.q.size() < 6 && i < 3000)
      begin
         @(posedge mclk);
         i++;
      end
      wd = 48'hX;
      if (sink.q.size() < 6)
      begin
         nErrors++;
         return;
      end
      for (int b = 0; b < 6; b++)
      begin
         wd = {wd[39:0], sink.q.pop_front()};
      end
   endtask : getWord

   task automatic checkTick;
      int c = 0;
      @(posedge mclk iff tick === 1'b1);
      do
      begin
         @(posedge mclk);
         c++;
      end while (tick !== 1'b1 && c < 200);
      `CHK(c, TICK)
   endtask : checkTick

   task automatic testRate;
      setup(4'h4, 2'h0, 11'h001, 24'h123456, 24'hF00001, 24'h000001);
      for (int j = 0; j < 4; j++)
      begin
         getWord(w);
         `CHK(w, {24'h123456 + 24'(j), 24'hF00001})
      end
      $display("test rate done");
   endtask : testRate

   task automatic testDelay;
      setup(4'h8, 2'h0, 11'h001, 24'h000001, 24'h00ABCD, 24'h000001);
      for (int j = 1; j <= 5; j++)
      begin
         getWord(w);
         `CHK(w, {(j < 3) ? 24'h000000 : 24'(j - 2), 24'h00ABCD})
      end
      $display("test delay done");
   endtask : testDelay

   task automatic testIncr;
      setup(4'h1, 2'h1, 11'h004, 24'h000100, 24'h001000, 24'h000100);
      for (int k = 1; k <= 3; k++)
      begin
         getWord(w);
         `CHK(w[47:24], scaled(256 * (16 * k - 6), `IOU_K_ANGLE))
         `CHK(w[23:0], scaled(4 * 24'h001000, `IOU_K_VEL))
      end
      $display("test incremental done");
   endtask : testIncr

   task automatic testAvg;
      setup(4'h2, 2'h2, 11'h004, 24'hFFFFFF, 24'hFFFFFB, 24'hFFFFFF);
      checkTick();
      for (int k = 1; k <= 3; k++)
      begin
         getWord(w);
         `CHK(w[47:24], 24'(2 - 4 * k))
         `CHK(w[23:0], 24'hFFFFFB)
      end
      $display("test average done");
   endtask : testAvg

   task automatic testInteg;
      setup(4'h3, 2'h3, 11'h001, 24'h7FFFFF, 24'h040000, 24'h000000);
      slow <= 1'b1;
      for (int k = 1; k <= 20; k++)
      begin
         getWord(w);
         `CHK(w[47:24], scaled(k * 64'sh7FFFFF, `IOU_K_ANGLE))
         `CHK(w[23:0], scaled(k * 64'sh040000, `IOU_K_GS))
      end
      `CHK(overrun, 1'b0)
      $display("test integrated done");
   endtask : testInteg

   task automatic testStall;
      setup(4'h0, 2'h0, 11'h001, 24'h000001, 24'h000022, 24'h000001);
      stall <= 1'b1;
      repeat (10 * TICK) @(posedge mclk);
      `CHK(overrun, 1'b1)
      `CHK({byteValid, byteOut}, 9'h100)
      stall <= 1'b0;
      getWord(w);
      `CHK(w, {24'h000001, 24'h000022})
      $display("test stall done");
   endtask : testStall

   task automatic results;
      $display("tests %0d errors %0d", nTests, nErrors);
      if (nErrors == 0 && nTests > 0)
      begin
         $display("TB: PASS");
      end
      else
      begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results

   initial
   begin
      testRate();
      testDelay();
      testIncr();
      testAvg();
      testInteg();
      testStall();
      results();
   end
endmodule : tb_top
